// ### common/dnco_defs.svh
// register offsets, reset values and field widths for the dual nco bank
// assumes a 32-bit apb slave, one aligned word per register
`ifndef DNCO_DEFS_SVH
`define DNCO_DEFS_SVH
// printed offsets are indices; byte address is four times the index
`define DNCO_IDX_AB_PHASE   6'h12
`define DNCO_IDX_CD_PHASE   6'h13
`define DNCO_IDX_AB_TUNE_LO 6'h14
`define DNCO_IDX_AB_TUNE_HI 6'h15
`define DNCO_IDX_CD_TUNE_LO 6'h16
`define DNCO_IDX_CD_TUNE_HI 6'h17
`define DNCO_IDX_SYNC_CTRL  6'h1f
`define DNCO_IDX_AB_ACC     6'h20
`define DNCO_IDX_CD_ACC     6'h21
`define DNCO_REG_RESET      16'h0000
`define DNCO_SYNC_RESET     16'h0000
`define DNCO_SYNC_ENA_BIT   0
`define DNCO_ACC_W          32
`define DNCO_WORD_W         16
`endif

// ### common/dnco_pkg.sv
// types shared by the dual nco bank
// assumes dnco_defs.svh for the constants
package dnco_pkg;
  typedef logic [15:0] dnco_half_t;
  typedef logic [31:0] dnco_word_t;
  typedef enum logic [1:0] {DNCO_AB, DNCO_CD} dnco_path_t;
endpackage : dnco_pkg

// ### common/dnco_cfg_if.sv
// carries one path's staged settings and its load strobe to an nco
// assumes a single clock domain
interface dnco_cfg_if;
  logic [15:0] phase_shift;
  logic [31:0] tuning;
  logic        load;
  logic [31:0] acc;
  logic [15:0] lut_addr;
  modport bank (output phase_shift, output tuning, output load,
                input acc, input lut_addr);
  modport nco  (input phase_shift, input tuning, input load,
                output acc, output lut_addr);
endinterface : dnco_cfg_if

// ### src/dnco_path.sv
// one nco path: active settings, accumulator and lookup address
// assumes load pulses one cycle after a synchronising write
`include "dnco_defs.svh"
module dnco_path
  import dnco_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  dnco_cfg_if.nco   cfg
);
  // ==========================================================
  // active mixer settings
  logic [31:0] tune_act_q;
  logic [15:0] phase_act_q;
  logic [31:0] acc_q;
  logic [15:0] addr_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tune_act_q  <= 32'h0000_0000;
      phase_act_q <= `DNCO_REG_RESET;
    end
    else if (cfg.load)
    begin
      tune_act_q  <= cfg.tuning;      // see R3
      phase_act_q <= cfg.phase_shift; // see R6
    end
  end

  // ==========================================================
  // accumulator, wraps mod 2^32; signed add is plain binary add
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_q <= 32'h0000_0000;
    else
      acc_q <= 32'(acc_q + tune_act_q); // see R12, see R8, see R9
  end

  // ==========================================================
  // lookup address from top accumulator bits plus offset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      addr_q <= 16'h0000;
    else
      addr_q <= 16'(acc_q[31:16] + phase_act_q); // see R1
  end

  assign cfg.acc      = acc_q;
  assign cfg.lut_addr = addr_q;

  // ==========================================================
  // checks
  property p_acc_step;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> acc_q == $past(acc_q) + $past(tune_act_q);
  endproperty
  a_acc_step: assert property (p_acc_step) // see R12
    else $error("accumulator step wrong");

  property p_addr_sum;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> addr_q == 16'($past(acc_q[31:16]) + $past(phase_act_q));
  endproperty
  a_addr_sum: assert property (p_addr_sum) // see R1
    else $error("lookup address wrong");

  property p_load_all;
    @(posedge pclk) disable iff (!presetn)
    cfg.load |=> tune_act_q == $past(cfg.tuning)
      && phase_act_q == $past(cfg.phase_shift);
  endproperty
  a_load_all: assert property (p_load_all) // see R3
    else $error("active settings not loaded together");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    !cfg.load |=> $stable(tune_act_q) && $stable(phase_act_q);
  endproperty
  a_hold: assert property (p_hold) // see R4
    else $error("active settings changed without load");

  c_load: cover property (@(posedge pclk) disable iff (!presetn)
    cfg.load ##1 tune_act_q[31]);
endmodule : dnco_path

// ### src/dnco_bank.sv
// apb register bank holding tuning and phase settings for two ncos
// assumes a 32-bit apb master on pclk, zero wait states
//
// Overview of operation
// R1 - each path adds its phase shift word to the top 16 accumulator bits.
// R2 - with auto-sync enabled, an ab phase shift write fires an ab sync.
// R3 - an ab sync loads ab phase shift and both ab tuning halves together.
// R4 - ab tuning half writes only fill holding storage until a sync.
// R5 - software writes both ab tuning halves before the ab phase shift.
// R6 - with auto-sync on, a cd phase shift write loads all three cd values.
// R7 - cd tuning writes leave the mixer alone; cd phase shift goes last.
// R8 - tuning words are signed, so negative words give negative frequency.
// R9 - one tuning lsb is a step of the sample rate over two to the 32nd.
// R10 - a tuning word is bits 15:0 at the lower index, 31:16 at the next.
// R11 - after reset all six tuning and phase shift registers hold zero.
// R12 - each 32-bit accumulator adds its tuning word every clock, mod 2^32.
//
// Chosen here: the APB slave port.
`include "dnco_defs.svh"
module dnco_bank
  import dnco_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [15:0] ab_lut_addr,
  output logic      [15:0] cd_lut_addr
);
  import dnco_pkg::*;

  // ==========================================================
  // bus decode
  logic       wr_en;
  logic       rd_en;
  logic [5:0] idx;
  logic       hit;
  logic       aligned;

  assign idx     = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;

  always_comb
  begin
    hit = 1'b0;
    case (idx)
      `DNCO_IDX_AB_PHASE, `DNCO_IDX_CD_PHASE,
      `DNCO_IDX_AB_TUNE_LO, `DNCO_IDX_AB_TUNE_HI,
      `DNCO_IDX_CD_TUNE_LO, `DNCO_IDX_CD_TUNE_HI,
      `DNCO_IDX_SYNC_CTRL, `DNCO_IDX_AB_ACC,
      `DNCO_IDX_CD_ACC: hit = aligned;
      default:          hit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !hit;

  // ==========================================================
  // holding registers
  dnco_half_t ab_phase_shift_q;
  dnco_half_t cd_phase_shift_q;
  dnco_half_t ab_tuning_low_q;
  dnco_half_t ab_tuning_high_q;
  dnco_half_t cd_tuning_low_q;
  dnco_half_t cd_tuning_high_q;
  dnco_half_t sync_ctrl_q;
  dnco_half_t wdata16;
  logic       lo_ok;

  assign wdata16 = pwdata[15:0];
  assign lo_ok   = wr_en && aligned && pstrb[0] && pstrb[1];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ab_phase_shift_q <= `DNCO_REG_RESET; // see R11
      cd_phase_shift_q <= `DNCO_REG_RESET;
      ab_tuning_low_q  <= `DNCO_REG_RESET;
      ab_tuning_high_q <= `DNCO_REG_RESET;
      cd_tuning_low_q  <= `DNCO_REG_RESET;
      cd_tuning_high_q <= `DNCO_REG_RESET;
      sync_ctrl_q      <= `DNCO_SYNC_RESET;
    end
    else if (lo_ok)
    begin
      case (idx)
        `DNCO_IDX_AB_PHASE:   ab_phase_shift_q <= wdata16;
        `DNCO_IDX_CD_PHASE:   cd_phase_shift_q <= wdata16;
        `DNCO_IDX_AB_TUNE_LO: ab_tuning_low_q  <= wdata16; // see R4
        `DNCO_IDX_AB_TUNE_HI: ab_tuning_high_q <= wdata16; // see R4
        `DNCO_IDX_CD_TUNE_LO: cd_tuning_low_q  <= wdata16; // see R7
        `DNCO_IDX_CD_TUNE_HI: cd_tuning_high_q <= wdata16; // see R7
        `DNCO_IDX_SYNC_CTRL:  sync_ctrl_q      <= wdata16;
        default:              ;
      endcase
    end
  end

  // ==========================================================
  // auto-sync strobes, one cycle after the phase write
  logic ab_sync_q;
  logic cd_sync_q;
  logic sync_ena;

  assign sync_ena = sync_ctrl_q[`DNCO_SYNC_ENA_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ab_sync_q <= 1'b0;
      cd_sync_q <= 1'b0;
    end
    else
    begin
      ab_sync_q <= lo_ok && sync_ena
                   && idx == `DNCO_IDX_AB_PHASE; // see R2, see R5
      cd_sync_q <= lo_ok && sync_ena
                   && idx == `DNCO_IDX_CD_PHASE; // see R6, see R7
    end
  end

  // ==========================================================
  // nco paths
  dnco_cfg_if ab_if ();
  dnco_cfg_if cd_if ();

  assign ab_if.phase_shift = ab_phase_shift_q;
  assign ab_if.tuning      = {ab_tuning_high_q, ab_tuning_low_q}; // see R10
  assign ab_if.load        = ab_sync_q; // see R3
  assign cd_if.phase_shift = cd_phase_shift_q;
  assign cd_if.tuning      = {cd_tuning_high_q, cd_tuning_low_q}; // see R10
  assign cd_if.load        = cd_sync_q; // see R6

  dnco_path u_ab
  (
    .pclk    (pclk),
    .presetn (presetn),
    .cfg     (ab_if.nco)
  );

  dnco_path u_cd
  (
    .pclk    (pclk),
    .presetn (presetn),
    .cfg     (cd_if.nco)
  );

  assign ab_lut_addr = ab_if.lut_addr;
  assign cd_lut_addr = cd_if.lut_addr;

  // ==========================================================
  // read data
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (idx)
      `DNCO_IDX_AB_PHASE:   rdata_d = {16'h0000, ab_phase_shift_q};
      `DNCO_IDX_CD_PHASE:   rdata_d = {16'h0000, cd_phase_shift_q};
      `DNCO_IDX_AB_TUNE_LO: rdata_d = {16'h0000, ab_tuning_low_q};
      `DNCO_IDX_AB_TUNE_HI: rdata_d = {16'h0000, ab_tuning_high_q};
      `DNCO_IDX_CD_TUNE_LO: rdata_d = {16'h0000, cd_tuning_low_q};
      `DNCO_IDX_CD_TUNE_HI: rdata_d = {16'h0000, cd_tuning_high_q};
      `DNCO_IDX_SYNC_CTRL:  rdata_d = {16'h0000, sync_ctrl_q};
      `DNCO_IDX_AB_ACC:     rdata_d = ab_if.acc;
      `DNCO_IDX_CD_ACC:     rdata_d = cd_if.acc;
      default:              rdata_d = 32'h0000_0000;
    endcase
  end

  // captured in setup so data is from a flop during access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_q <= aligned ? rdata_d : 32'h0000_0000;
  end

  assign prdata = rd_en ? prdata_q : 32'h0000_0000;

  // ==========================================================
  // checks
  property p_ab_sync;
    @(posedge pclk) disable iff (!presetn)
    (lo_ok && sync_ena && idx == `DNCO_IDX_AB_PHASE) |=> ab_sync_q;
  endproperty
  a_ab_sync: assert property (p_ab_sync) // see R2
    else $error("ab auto-sync missing");

  property p_cd_sync;
    @(posedge pclk) disable iff (!presetn)
    cd_sync_q |-> $past(lo_ok) && $past(sync_ena)
      && $past(idx) == `DNCO_IDX_CD_PHASE;
  endproperty
  a_cd_sync: assert property (p_cd_sync) // see R6
    else $error("cd auto-sync without cause");

  property p_tune_no_sync;
    @(posedge pclk) disable iff (!presetn)
    (lo_ok && idx inside {`DNCO_IDX_AB_TUNE_LO, `DNCO_IDX_AB_TUNE_HI})
      |=> !ab_sync_q;
  endproperty
  a_tune_no_sync: assert property (p_tune_no_sync) // see R4
    else $error("ab tuning write caused sync");

  property p_cd_tune_no_sync;
    @(posedge pclk) disable iff (!presetn)
    (lo_ok && idx inside {`DNCO_IDX_CD_TUNE_LO, `DNCO_IDX_CD_TUNE_HI})
      |=> !cd_sync_q;
  endproperty
  a_cd_tune_no_sync: assert property (p_cd_tune_no_sync) // see R7
    else $error("cd tuning write caused sync");

  property p_word_join;
    @(posedge pclk) disable iff (!presetn)
    (lo_ok && idx == `DNCO_IDX_AB_TUNE_HI)
      |=> ab_if.tuning[31:16] == $past(wdata16);
  endproperty
  a_word_join: assert property (p_word_join) // see R10
    else $error("high half placed wrong");

  property p_reset_zero;
    @(posedge pclk)
    $rose(presetn) |-> ab_if.tuning == 32'h0000_0000
      && cd_if.tuning == 32'h0000_0000 && ab_phase_shift_q == 16'h0000
      && cd_phase_shift_q == 16'h0000;
  endproperty
  a_reset_zero: assert property (p_reset_zero) // see R11
    else $error("registers not zero after reset");

  property p_ab_sync_cause;
    @(posedge pclk) disable iff (!presetn)
    ab_sync_q |-> $past(lo_ok) && $past(sync_ena)
      && $past(idx) == `DNCO_IDX_AB_PHASE;
  endproperty
  a_ab_sync_cause: assert property (p_ab_sync_cause) // see R2
    else $error("ab auto-sync without cause");

  property p_cd_sync_fire;
    @(posedge pclk) disable iff (!presetn)
    (lo_ok && sync_ena && idx == `DNCO_IDX_CD_PHASE) |=> cd_sync_q;
  endproperty
  a_cd_sync_fire: assert property (p_cd_sync_fire) // see R6
    else $error("cd auto-sync missing");

  property p_sync_off;
    @(posedge pclk) disable iff (!presetn)
    (lo_ok && !sync_ena) |=> !ab_sync_q && !cd_sync_q;
  endproperty
  a_sync_off: assert property (p_sync_off) // see R2, see R6
    else $error("auto-sync while disabled");

  property p_lo_join;
    @(posedge pclk) disable iff (!presetn)
    (lo_ok && idx == `DNCO_IDX_AB_TUNE_LO)
      |=> ab_if.tuning[15:0] == $past(wdata16);
  endproperty
  a_lo_join: assert property (p_lo_join) // see R10
    else $error("ab low half placed wrong");

  property p_cd_join;
    @(posedge pclk) disable iff (!presetn)
    (lo_ok && idx == `DNCO_IDX_CD_TUNE_HI)
      |=> cd_if.tuning[31:16] == $past(wdata16);
  endproperty
  a_cd_join: assert property (p_cd_join) // see R10
    else $error("cd high half placed wrong");

  property p_cd_lo_join;
    @(posedge pclk) disable iff (!presetn)
    (lo_ok && idx == `DNCO_IDX_CD_TUNE_LO)
      |=> cd_if.tuning[15:0] == $past(wdata16);
  endproperty
  a_cd_lo_join: assert property (p_cd_lo_join) // see R10
    else $error("cd low half placed wrong");

  property p_reset_lut;
    @(posedge pclk)
    $rose(presetn) |-> ab_lut_addr == 16'h0000 && cd_lut_addr == 16'h0000;
  endproperty
  a_reset_lut: assert property (p_reset_lut) // see R11
    else $error("lookup address not zero after reset");

  c_ab_sync: cover property (@(posedge pclk) disable iff (!presetn)
    ab_sync_q);
  c_cd_sync: cover property (@(posedge pclk) disable iff (!presetn)
    cd_sync_q);
  c_neg_tune: cover property (@(posedge pclk) disable iff (!presetn)
    ab_sync_q && ab_tuning_high_q[15]);
  c_cd_neg: cover property (@(posedge pclk) disable iff (!presetn)
    cd_sync_q && cd_tuning_high_q[15]);
endmodule : dnco_bank

// ### sim/testbench.sv
// self-checking bench for the dual nco register bank
// assumes dnco_bank on a 25 MHz pclk, apb master driven here
`include "dnco_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import dnco_pkg::*;

  // ==========================================================
  // signals
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] ab_lut_addr;
  logic [15:0] cd_lut_addr;
  logic [31:0] rd;
  logic        err;
  dnco_half_t  dlt;
  int          n_errors;
  int          checks;
  int          cycles;

  dnco_bank uut (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .pstrb       (pstrb),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .ab_lut_addr (ab_lut_addr),
    .cd_lut_addr (cd_lut_addr)
  );

  // ==========================================================
  // clock and timeout
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [5:0] idx,
                      input logic [15:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {16'h0000, d};
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    xfer(1'b1, idx, d, 4'hf);
  endtask : wr

  // step of one lookup address over n cycles, after the load settles
  task automatic lut_step(input logic cd, input int n);
    logic [15:0] a;
    logic [15:0] b;
    repeat (4) @(posedge pclk);
    #1 a = cd ? cd_lut_addr : ab_lut_addr;
    repeat (n) @(posedge pclk);
    #1 b = cd ? cd_lut_addr : ab_lut_addr;
    dlt = b - a;
  endtask : lut_step

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // tests
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    n_errors = 0;
    checks = 0;
    cycles = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b0, 6'h12 + 6'(i), 16'h0000, 4'h0);
      chk(rd, 32'h0000_0000);
    end
    xfer(1'b0, `DNCO_IDX_SYNC_CTRL, 16'h0000, 4'h0);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 6; i++)
    begin
      wr(6'h12 + 6'(i), {4{4'(i + 1)}});
      xfer(1'b0, 6'h12 + 6'(i), 16'h0000, 4'h0);
      chk(rd, {16'h0000, {4{4'(i + 1)}}});
    end
    repeat (4) @(posedge pclk);
    chk({ab_lut_addr, cd_lut_addr}, 32'h0000_0000);
    xfer(1'b1, `DNCO_IDX_AB_PHASE, 16'hffff, 4'h1);
    xfer(1'b0, `DNCO_IDX_AB_PHASE, 16'h0000, 4'h0);
    chk(rd, 32'h0000_1111);
    xfer(1'b0, 6'h30, 16'h0000, 4'h0);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    wr(`DNCO_IDX_SYNC_CTRL, 16'h0001);
    wr(`DNCO_IDX_AB_TUNE_LO, 16'h0000);
    wr(`DNCO_IDX_AB_TUNE_HI, 16'h0000);
    wr(`DNCO_IDX_AB_PHASE, 16'h1234);
    repeat (4) @(posedge pclk);
    chk({16'h0000, ab_lut_addr}, 32'h0000_1234);
    chk({16'h0000, cd_lut_addr}, 32'h0000_0000);
    wr(`DNCO_IDX_AB_TUNE_HI, 16'h0001);
    repeat (4) @(posedge pclk);
    chk({16'h0000, ab_lut_addr}, 32'h0000_1234);
    wr(`DNCO_IDX_AB_PHASE, 16'h1234);
    lut_step(1'b0, 1);
    chk({16'h0000, dlt}, 32'h0000_0001);
    wr(`DNCO_IDX_AB_TUNE_LO, 16'h8000);
    wr(`DNCO_IDX_AB_TUNE_HI, 16'h0000);
    wr(`DNCO_IDX_AB_PHASE, 16'h0000);
    lut_step(1'b0, 2);
    chk({16'h0000, dlt}, 32'h0000_0001);
    wr(`DNCO_IDX_AB_TUNE_LO, 16'h0000);
    wr(`DNCO_IDX_AB_TUNE_HI, 16'h8000);
    wr(`DNCO_IDX_AB_PHASE, 16'h0000);
    lut_step(1'b0, 2);
    chk({16'h0000, dlt}, 32'h0000_0000);
    wr(`DNCO_IDX_CD_TUNE_LO, 16'h0000);
    wr(`DNCO_IDX_CD_TUNE_HI, 16'hffff);
    wr(`DNCO_IDX_CD_PHASE, 16'h0100);
    lut_step(1'b1, 1);
    chk({16'h0000, dlt}, 32'h0000_ffff);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, `DNCO_IDX_CD_TUNE_HI, 16'h0000, 4'h0);
    chk(rd, 32'h0000_0000);
    xfer(1'b0, `DNCO_IDX_CD_ACC, 16'h0000, 4'h0);
    chk(rd, 32'h0000_0000);
    chk({ab_lut_addr, cd_lut_addr}, 32'h0000_0000);
    print_verdict();
  end
endmodule : testbench
